// file: src/rxesq_top.v
// Receive configuration, receive event flags and the interrupt status queue.
`timescale 1ns/10ps
`include "rxesq_regs.vh"

module rxesq_top (
  input wire clk,
  input wire rst_b,
  // Host register port: one-cycle strobes, memory-mode offset or I/O-mode offset.
  input wire regRd,
  input wire regWr,
  input wire ioMode,
  input wire [11:0] regAddr,
  input wire [15:0] regWrData,
  output reg [15:0] regRdData,
  // Optional EEPROM-supplied initial configuration, one-cycle load strobe.
  input wire eepromLoad,
  input wire [15:0] eepromCfg,
  // Frame end report from the receive MAC, one-cycle strobe.
  input wire frameDone,
  input wire [10:0] frameLen,
  input wire fcsGood,
  input wire addrHashed,
  input wire [5:0] hashIndex,
  input wire stationMatch,
  input wire multicastDest,
  input wire dribble,
  input wire [47:0] destAddr,
  // Other queue sources: ten data bits with a one-cycle strobe each.
  input wire txEvtStrobe,
  input wire [9:0] txEvtBits,
  input wire bufEvtStrobe,
  input wire [9:0] bufEvtBits,
  input wire missOvfStrobe,
  input wire [9:0] missCount,
  input wire colOvfStrobe,
  input wire [9:0] colCount,
  // Receive path steering.
  input wire autoDmaCond,
  input wire backToBack,
  output reg frameAccept,
  output reg frameDiscard,
  output reg [10:0] storeLen,
  output reg useDma,
  output reg useStream,
  output reg skipFrame,
  output wire irq
);

  reg [15:0] receive_configuration;
  reg [15:0] receive_accept_control;
  reg [9:0] rxEvt;
  reg [9:0] rxStat;
  reg [10:0] rxLen;
  reg [15:0] qMem [0:`RXESQ_QDEPTH-1];
  reg [`RXESQ_QPTRW:0] qWr;
  reg [`RXESQ_QPTRW:0] qRd;
  reg [9:0] next_evt;
  reg next_irqEvt;
  reg passFilter;
  reg goodFrame;
  reg isRunt;
  reg isXtra;
  reg isBcast;
  reg next_accept;
  reg [15:0] pushWord [0:4];
  reg [4:0] pushReq;
  reg [15:0] readMux;
  integer i;

  wire qEmpty = (qWr == qRd);
  wire cfgSel = !ioMode && (regAddr == `RXESQ_OFS_CFG);
  wire ctlSel = !ioMode && (regAddr == `RXESQ_OFS_CTL);
  wire evtSel = !ioMode && (regAddr == `RXESQ_OFS_EVT);
  wire statSel = !ioMode && (regAddr == `RXESQ_OFS_STAT);
  wire lenSel = !ioMode && (regAddr == `RXESQ_OFS_LEN);
  // Queue address
  // window and I/O offsets.
  wire isqSel = ioMode ? (regAddr[3:0] == `RXESQ_IO_ISQ) : (regAddr == `RXESQ_OFS_ISQ);
  wire isqPop = regRd && isqSel && !qEmpty;
  wire evtRead = regRd && evtSel;

  // Builds a queue word from a source number and ten data bits.
  // number low, data high.
  function [15:0] packWord;
    input [5:0] num;
    input [9:0] bits;
    begin
      packWord = {bits, num};
    end
  endfunction

  // Frame classification from the MAC's end-of-frame report.
  always @* begin
    isRunt = (frameLen < `RXESQ_MIN_LEN);
    isXtra = (frameLen > `RXESQ_MAX_LEN);
    goodFrame = fcsGood && !isRunt && !isXtra;
    isBcast = (destAddr == 48'hFFFFFFFFFFFF);
    passFilter = receive_accept_control[`RXESQ_B_PROMA] || (stationMatch && receive_accept_control[`RXESQ_B_INDA]) ||
                 (isBcast && receive_accept_control[`RXESQ_B_BCASTA]) ||
                 (addrHashed && multicastDest && receive_accept_control[`RXESQ_B_MCASTA]) ||
                 (addrHashed && !multicastDest && receive_accept_control[`RXESQ_B_HASHA]);
    next_accept = passFilter && (frameLen >= `RXESQ_TINY_LEN) &&
                  ((goodFrame && receive_accept_control[`RXESQ_B_OKA]) || (!fcsGood && receive_accept_control[`RXESQ_B_FCSA]) ||
                   (isRunt && receive_accept_control[`RXESQ_B_RUNTA]) || (isXtra && receive_accept_control[`RXESQ_B_XTRAA]));
    if (frameLen < `RXESQ_TINY_LEN) begin
      next_accept = 1'b0;
    end
    next_evt = 10'h000;
    next_evt[`RXESQ_E_DRIB - 6] = dribble;
    next_evt[`RXESQ_E_OK - 6] = goodFrame;
    next_evt[`RXESQ_E_HASHED - 6] = addrHashed;
    next_evt[`RXESQ_E_HASHHIT - 6] = addrHashed && !multicastDest && receive_accept_control[`RXESQ_B_HASHA];
    if (addrHashed && goodFrame) begin
      next_evt[9:4] = hashIndex;
    end else begin
      next_evt[`RXESQ_E_IND - 6] = stationMatch && goodFrame && receive_accept_control[`RXESQ_B_INDA];
      next_evt[`RXESQ_E_BCAST - 6] = isBcast && goodFrame && receive_accept_control[`RXESQ_B_BCASTA];
      next_evt[`RXESQ_E_FCS - 6] = !fcsGood;
      next_evt[`RXESQ_E_RUNT - 6] = isRunt;
      next_evt[`RXESQ_E_XTRA - 6] = isXtra;
    end
    // no good-frame interrupt in DMA mode.
    next_irqEvt = (goodFrame && receive_configuration[`RXESQ_B_OKIE] && !useDma) ||
                  (isRunt && receive_configuration[`RXESQ_B_SHORT_FRAME_IRQ_ENABLE]) ||
                  (isXtra && receive_configuration[`RXESQ_B_XTRAIE]) ||
                  (!fcsGood && receive_configuration[`RXESQ_B_FCSIE]);
  end

  // Pending pushes from the five sources, in fixed same-cycle order.
  // five queue sources.
  always @* begin
    pushReq = {colOvfStrobe, missOvfStrobe, bufEvtStrobe, txEvtStrobe, frameDone && next_irqEvt};
    pushWord[0] = packWord(`RXESQ_NUM_RXE, next_evt);
    pushWord[1] = packWord(`RXESQ_NUM_TXE, txEvtBits);
    pushWord[2] = packWord(`RXESQ_NUM_BUF, bufEvtBits);
    pushWord[3] = packWord(`RXESQ_NUM_MISS, missCount);
    pushWord[4] = packWord(`RXESQ_NUM_COL, colCount);
  end

  // Configuration and accept control registers.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      receive_configuration <= `RXESQ_CFG_RESET;
      receive_accept_control <= `RXESQ_CTL_RESET;
      skipFrame <= 1'b0;
    end else begin
      skipFrame <= regWr && cfgSel && regWrData[`RXESQ_B_SKIP] && !receive_configuration[`RXESQ_B_DMAONLY];
      if (eepromLoad) begin
        receive_configuration <= {eepromCfg[15:7], 1'b0, `RXESQ_NUM_CFG};
      end else if (regWr && cfgSel) begin
        // fixed low code, skip not stored.
        receive_configuration <= {regWrData[15:7], 1'b0, `RXESQ_NUM_CFG};
      end
      if (regWr && ctlSel) begin
        receive_accept_control <= {regWrData[15:6], `RXESQ_NUM_CTL};
      end
    end
  end

  // Receive event, status copy, length and path steering.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxEvt <= 10'h000;
      rxStat <= 10'h000;
      rxLen <= 11'h000;
      frameAccept <= 1'b0;
      frameDiscard <= 1'b0;
      storeLen <= 11'h000;
      useDma <= 1'b0;
      useStream <= 1'b0;
    end else begin
      frameAccept <= frameDone && next_accept;
      frameDiscard <= frameDone && !next_accept;
      useDma <= receive_configuration[`RXESQ_B_DMAONLY] || (receive_configuration[`RXESQ_B_AUTODMA] && autoDmaCond);
      useStream <= receive_configuration[`RXESQ_B_STREAM] && backToBack && passFilter &&
                   (receive_configuration[`RXESQ_B_DMAONLY] || receive_configuration[`RXESQ_B_AUTODMA]);
      // clear on read, new frame wins.
      if (frameDone) begin
        rxEvt <= next_evt;
        // status copy not cleared by reads.
        rxStat <= next_evt;
        storeLen <= isXtra ? (receive_configuration[`RXESQ_B_KEEPFCS] ? `RXESQ_MAX_LEN : `RXESQ_MAX_LEN - `RXESQ_FCS_LEN) :
                    (receive_configuration[`RXESQ_B_KEEPFCS] ? frameLen : frameLen - `RXESQ_FCS_LEN);
        if (goodFrame) begin
          rxLen <= receive_configuration[`RXESQ_B_KEEPFCS] ? frameLen : frameLen - `RXESQ_FCS_LEN;
        end
      end else if (evtRead) begin
        rxEvt <= 10'h000;
      end
    end
  end

  // Status queue: pushes in source order, pop on read, overflow drops newest.
  // queue enabled events.
  always @(posedge clk or negedge rst_b) begin : qProc
    reg [`RXESQ_QPTRW:0] wp;
    reg [`RXESQ_QPTRW:0] fill;
    if (!rst_b) begin
      qWr <= {(`RXESQ_QPTRW+1){1'b0}};
      qRd <= {(`RXESQ_QPTRW+1){1'b0}};
      for (i = 0; i < `RXESQ_QDEPTH; i = i + 1) begin
        qMem[i] <= `RXESQ_ISQ_RESET;
      end
    end else begin
      wp = qWr;
      for (i = 0; i < 5; i = i + 1) begin
        // Fill level kept at pointer width, so wrapped pointers still give the true count.
        fill = wp - qRd;
        if (pushReq[i] && (fill < `RXESQ_QDEPTH)) begin
          qMem[wp[`RXESQ_QPTRW-1:0]] <= pushWord[i];
          wp = wp + 1'b1;
        end
      end
      qWr <= wp;
      if (isqPop) begin
        qRd <= qRd + 1'b1;
      end
    end
  end

  // Read data multiplexer.
  always @* begin
    readMux = 16'h0000;
    if (isqSel) begin
      readMux = qEmpty ? `RXESQ_ISQ_RESET : qMem[qRd[`RXESQ_QPTRW-1:0]];
    end else if (cfgSel) begin
      readMux = receive_configuration;
    end else if (ctlSel) begin
      readMux = receive_accept_control;
    end else if (evtSel) begin
      readMux = {rxEvt, `RXESQ_NUM_RXE};
    end else if (statSel) begin
      readMux = {rxStat, `RXESQ_NUM_RXE};
    end else if (lenSel) begin
      readMux = {5'h00, rxLen};
    end
  end

  // Read data is registered on the read strobe.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 16'h0000;
    end else if (regRd) begin
      regRdData <= readMux;
    end
  end

  // Interrupt line high while any entry waits.
  assign irq = !qEmpty;

endmodule

// file: src/rxesq_regs.vh
// Register offsets, field positions, reset values and codes of the receive event and status queue block.
// What this block does
// - Enabled event sets source bits, queues that register, raises interrupt output.
// - Queue entries come from receive, transmit, buffer events and two counter overflows.
// - Queue register answers at window offset 120h and I/O offset 0008h.
// - Queue word holds source number in low six bits, data in upper ten.
// - Configuration low bits read 000011; receive event low bits read 000100.
// - Writing skip deletes last committed frame once per write; not with DMA-always.
// - Stream enable streams back-to-back filtered frames; needs a DMA mode set.
// - Good-frame interrupt when enabled, but never when reception uses DMA.
// - DMA-always uses receive DMA for every frame, overriding auto switch.
// - Auto switch moves from on-chip buffering to receive DMA when conditions hold.
// - Keep-FCS stores and counts the four CRC bytes in the length.
// - Short-frame interrupt under 64 bytes; frames under 8 bytes always discarded.
// - Oversize interrupt over 1518 bytes, whatever the CRC result.
// - Configuration resets to 0x0003, or an EEPROM-loaded value.
// - Hash flag set only when hashed, hash accept set and hash match.
// - Good-frame flag on correct CRC and valid length; length then valid.
// - With hash and good flags set, bits F..A carry the hash index.
// - Station address flag needs address match, good frame and accept control.
// - Broadcast flag needs all-ones destination, good frame and accept control.
// - Flag bad CRC, short, oversize frames; drop bytes past 1518.
// - Reading the receive event register clears its event bits.
// - Status copy mirrors receive event and is not cleared by reads.
// - Accept control register gates accepted frames and flag setting.
`ifndef RXESQ_REGS_VH
`define RXESQ_REGS_VH
`define RXESQ_OFS_CFG 12'h102
`define RXESQ_OFS_CTL 12'h104
`define RXESQ_OFS_ISQ 12'h120
`define RXESQ_OFS_EVT 12'h124
`define RXESQ_OFS_STAT 12'h400
`define RXESQ_OFS_LEN 12'h402
`define RXESQ_IO_ISQ 4'h8
`define RXESQ_CFG_RESET 16'h0003
`define RXESQ_CTL_RESET 16'h0005
`define RXESQ_ISQ_RESET 16'h0000
`define RXESQ_EVT_RESET 16'h0004
`define RXESQ_NUM_CFG 6'h03
`define RXESQ_NUM_CTL 6'h05
`define RXESQ_NUM_RXE 6'h04
`define RXESQ_NUM_TXE 6'h08
`define RXESQ_NUM_BUF 6'h0C
`define RXESQ_NUM_MISS 6'h10
`define RXESQ_NUM_COL 6'h12
`define RXESQ_B_SKIP 6
`define RXESQ_B_STREAM 7
`define RXESQ_B_OKIE 8
`define RXESQ_B_DMAONLY 9
`define RXESQ_B_AUTODMA 10
`define RXESQ_B_KEEPFCS 11
`define RXESQ_B_FCSIE 12
`define RXESQ_B_SHORT_FRAME_IRQ_ENABLE 13
`define RXESQ_B_XTRAIE 14
`define RXESQ_B_HASHA 6
`define RXESQ_B_PROMA 7
`define RXESQ_B_OKA 8
`define RXESQ_B_MCASTA 9
`define RXESQ_B_INDA 10
`define RXESQ_B_BCASTA 11
`define RXESQ_B_FCSA 12
`define RXESQ_B_RUNTA 13
`define RXESQ_B_XTRAA 14
`define RXESQ_E_DRIB 7
`define RXESQ_E_HASHHIT 6
`define RXESQ_E_OK 8
`define RXESQ_E_HASHED 9
`define RXESQ_E_IND 10
`define RXESQ_E_BCAST 11
`define RXESQ_E_FCS 12
`define RXESQ_E_RUNT 13
`define RXESQ_E_XTRA 14
`define RXESQ_MIN_LEN 11'd64
`define RXESQ_MAX_LEN 11'd1518
`define RXESQ_TINY_LEN 11'd8
`define RXESQ_FCS_LEN 11'd4
`define RXESQ_QDEPTH 8
`define RXESQ_QPTRW 3
`endif

// file: test/rxesq_chk_sva.sv
// Port checker for the receive event and status queue block.
`timescale 1ns/10ps
`include "rxesq_regs.vh"
module rxesq_chk (
  input wire clk,
  input wire rst_b,
  input wire regRd,
  input wire regWr,
  input wire ioMode,
  input wire [11:0] regAddr,
  input wire [15:0] regWrData,
  input wire [15:0] regRdData,
  input wire eepromLoad,
  input wire [15:0] eepromCfg,
  input wire frameDone,
  input wire [10:0] frameLen,
  input wire txEvtStrobe,
  input wire frameAccept,
  input wire frameDiscard,
  input wire [10:0] storeLen,
  input wire useDma,
  input wire skipFrame,
  input wire irq
);
  reg dmaOnly;
  wire cfgWr = regWr && !ioMode && regAddr == `RXESQ_OFS_CFG;
  wire memRd = regRd && !ioMode;
  wire isqRd = regRd && (ioMode ? regAddr[3:0] == `RXESQ_IO_ISQ : regAddr == `RXESQ_OFS_ISQ);
  // Follows the DMA-always bit as the host or the loader sets it.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dmaOnly <= 1'b0;
    end else if (eepromLoad) begin
      dmaOnly <= eepromCfg[`RXESQ_B_DMAONLY];
    end else if (cfgWr) begin
      dmaOnly <= regWrData[`RXESQ_B_DMAONLY];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_tiny_discard: assert property (frameDone && frameLen < `RXESQ_TINY_LEN |=> frameDiscard && !frameAccept)
    else $error("tiny frame not discarded");
  a_oversize_cut: assert property (frameDone && frameLen > `RXESQ_MAX_LEN |=> !frameAccept || storeLen <= `RXESQ_MAX_LEN)
    else $error("oversize frame stored too long");
  a_empty_zero: assert property (isqRd && !irq |=> regRdData == 16'h0000)
    else $error("empty queue read not zero");
  a_isq_source: assert property (isqRd && irq |=> regRdData[5:0] inside {6'h04, 6'h08, 6'h0C, 6'h10, 6'h12})
    else $error("queue word has bad source number");
  a_cfg_code: assert property (memRd && regAddr == `RXESQ_OFS_CFG |=> regRdData[5:0] == `RXESQ_NUM_CFG)
    else $error("configuration code wrong");
  a_evt_code: assert property (memRd && regAddr == `RXESQ_OFS_EVT |=> regRdData[5:0] == `RXESQ_NUM_RXE)
    else $error("receive event code wrong");
  a_tx_raises: assert property (txEvtStrobe |=> irq)
    else $error("event did not raise irq");
  a_dma_always: assert property (dmaOnly && $past(dmaOnly) && $past(dmaOnly, 2) |-> useDma)
    else $error("DMA-always without DMA");
  a_skip_once: assert property (skipFrame |-> $past(cfgWr) && $past(regWrData[`RXESQ_B_SKIP]))
    else $error("skip acted without a skip write");
  a_skip_fires: assert property (cfgWr && regWrData[`RXESQ_B_SKIP] && !dmaOnly |-> ##[1:2] skipFrame)
    else $error("skip write ignored");
  a_skip_blocked: assert property (cfgWr && regWrData[`RXESQ_B_SKIP] && dmaOnly |=> !skipFrame)
    else $error("skip acted under DMA-always");
  c_accept: cover property (frameDone ##1 frameAccept);
  c_skip: cover property (skipFrame);
  c_pop: cover property (isqRd && irq);
endmodule
bind rxesq_top rxesq_chk u_rxesq_chk (.clk(clk), .rst_b(rst_b), .regRd(regRd), .regWr(regWr), .ioMode(ioMode),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .eepromLoad(eepromLoad), .eepromCfg(eepromCfg),
  .frameDone(frameDone), .frameLen(frameLen), .txEvtStrobe(txEvtStrobe), .frameAccept(frameAccept),
  .frameDiscard(frameDiscard), .storeLen(storeLen), .useDma(useDma), .skipFrame(skipFrame), .irq(irq));

// file: test/rxesq_host.sv
// Host processor model issuing one-cycle register strobes.
`timescale 1ns/10ps
module rxesq_host (
  input wire clk,
  output reg regRd,
  output reg regWr,
  output reg ioMode,
  output reg [11:0] regAddr,
  output reg [15:0] regWrData,
  input wire [15:0] regRdData
);
  // Idle bus at time zero.
  initial begin
    regRd = 1'b0;
    regWr = 1'b0;
    ioMode = 1'b0;
    regAddr = 12'h000;
    regWrData = 16'h0000;
  end
  // Write strobe for one cycle; released lines show the inverse so stale values never look valid.
  task wr(input [11:0] a, input [15:0] d);
    begin
      @(negedge clk);
      ioMode = 1'b0;
      regAddr = a;
      regWrData = d;
      regWr = 1'b1;
      @(negedge clk);
      regWr = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
    end
  endtask
  // Read strobe for one cycle; data is taken a cycle after the strobe edge.
  task rd(input io, input [11:0] a, output [15:0] d);
    begin
      @(negedge clk);
      ioMode = io;
      regAddr = a;
      regRd = 1'b1;
      @(negedge clk);
      regRd = 1'b0;
      regAddr = ~a;
      @(negedge clk);
      d = regRdData;
    end
  endtask
endmodule

// file: test/rxesq_top_tb_top.sv
// Self-checking bench for the receive event and status queue block.
`timescale 1ns/10ps
`include "rxesq_regs.vh"
module rxesq_top_tb_top;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg frameDone = 1'b0;
  reg [10:0] frameLen = 11'h000;
  reg fcsGood = 1'b0, addrHashed = 1'b0, stationMatch = 1'b0, multicastDest = 1'b0;
  reg [5:0] hashIndex = 6'h2A;
  reg txS = 1'b0, bufS = 1'b0, missS = 1'b0, colS = 1'b0;
  reg [9:0] evBits = 10'h000;
  reg autoDmaCond = 1'b0, backToBack = 1'b0;
  reg [47:0] destAddr = 48'h000000000000;
  reg eepromLoad = 1'b0;
  reg [15:0] eepromCfg = 16'h0000;
  wire regRd, regWr, ioMode, frameAccept, frameDiscard, useDma, useStream, skipFrame, irq;
  wire [11:0] regAddr;
  wire [15:0] regWrData, regRdData;
  wire [10:0] storeLen;
  reg [15:0] rv;
  reg [15:0] expq [$];
  integer bad_count = 0;
  integer tests_run = 0;
  integer i;
  // Free-running 125 MHz clock.
  always #4 clk = ~clk;
  rxesq_host u_rxesq_host (.clk(clk), .regRd(regRd), .regWr(regWr), .ioMode(ioMode), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));
  rxesq_top u_rxesq_top (.clk(clk), .rst_b(rst_b), .regRd(regRd), .regWr(regWr), .ioMode(ioMode),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .eepromLoad(eepromLoad), .eepromCfg(eepromCfg),
    .frameDone(frameDone), .frameLen(frameLen), .fcsGood(fcsGood), .addrHashed(addrHashed), .hashIndex(hashIndex),
    .stationMatch(stationMatch), .multicastDest(multicastDest), .dribble(1'b0), .destAddr(destAddr),
    .txEvtStrobe(txS), .txEvtBits(evBits), .bufEvtStrobe(bufS), .bufEvtBits(evBits), .missOvfStrobe(missS),
    .missCount(evBits), .colOvfStrobe(colS), .colCount(evBits), .autoDmaCond(autoDmaCond),
    .backToBack(backToBack), .frameAccept(frameAccept), .frameDiscard(frameDiscard), .storeLen(storeLen),
    .useDma(useDma), .useStream(useStream), .skipFrame(skipFrame), .irq(irq));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask
  // Frame end report held for one cycle.
  task frame(input [10:0] len, input good, input hashed, input station, input mcast, input [15:0] evt);
    begin
      @(negedge clk);
      frameLen = len;
      fcsGood = good;
      addrHashed = hashed;
      stationMatch = station;
      multicastDest = mcast;
      frameDone = 1'b1;
      @(negedge clk);
      frameDone = 1'b0;
      if (evt != 16'h0000) expq.push_back(evt);
    end
  endtask
  // One strobe of a non-receive source, expected word queued as data over source number.
  task src(input [1:0] k, input [9:0] b);
    begin
      @(negedge clk);
      evBits = b;
      {txS, bufS, missS, colS} = 4'h8 >> k;
      expq.push_back({b, k == 0 ? `RXESQ_NUM_TXE : k == 1 ? `RXESQ_NUM_BUF : k == 2 ? `RXESQ_NUM_MISS : `RXESQ_NUM_COL});
      @(negedge clk);
      {txS, bufS, missS, colS} = 4'h0;
    end
  endtask
  // Pops every expected entry, then one read of the empty queue.
  task drain(input io);
    begin
      while (expq.size() > 0) begin
        u_rxesq_host.rd(io, io ? {8'h00, `RXESQ_IO_ISQ} : `RXESQ_OFS_ISQ, rv);
        chk(rv, expq.pop_front());
      end
      u_rxesq_host.rd(io, io ? {8'h00, `RXESQ_IO_ISQ} : `RXESQ_OFS_ISQ, rv);
      chk(rv, 16'h0000);
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    u_rxesq_host.rd(1'b0, `RXESQ_OFS_CFG, rv);
    chk(rv, `RXESQ_CFG_RESET);
    u_rxesq_host.rd(1'b0, `RXESQ_OFS_EVT, rv);
    chk(rv, `RXESQ_EVT_RESET);
    drain(1'b0);
    $display("test 1 done");
    u_rxesq_host.wr(`RXESQ_OFS_CTL, 16'h7F00);
    u_rxesq_host.wr(`RXESQ_OFS_CFG, 16'h7103);
    frame(11'd100, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0504);
    chk({14'h0000, frameAccept, frameDiscard}, 16'h0002);
    u_rxesq_host.rd(1'b0, `RXESQ_OFS_EVT, rv);
    chk(rv, 16'h0504);
    u_rxesq_host.rd(1'b0, `RXESQ_OFS_EVT, rv);
    chk(rv, 16'h0004);
    u_rxesq_host.rd(1'b0, `RXESQ_OFS_STAT, rv);
    chk(rv, 16'h0504);
    u_rxesq_host.rd(1'b0, `RXESQ_OFS_LEN, rv);
    chk(rv, 16'h0060);
    for (i = 0; i < 4; i = i + 1) src(i, 10'h155 ^ (i * 10'h0C3));
    drain(1'b0);
    $display("test 2 done");
    frame(11'd1600, 1'b0, 1'b0, 1'b0, 1'b0, 16'h5004);
    chk({frameAccept, frameDiscard, 3'h0, storeLen}, 16'h45EA);
    frame(11'd40, 1'b1, 1'b0, 1'b0, 1'b0, 16'h2004);
    frame(11'd200, 1'b1, 1'b1, 1'b0, 1'b1, 16'hAB04);
    u_rxesq_host.wr(`RXESQ_OFS_CFG, 16'h7903);
    // All-ones destination from here on, so later frames pass the filter as broadcast.
    destAddr = 48'hFFFFFFFFFFFF;
    frame(11'd100, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0904);
    u_rxesq_host.rd(1'b0, `RXESQ_OFS_LEN, rv);
    chk(rv, 16'h0064);
    drain(1'b1);
    $display("test 3 done");
    u_rxesq_host.wr(`RXESQ_OFS_CFG, 16'h0303);
    frame(11'd100, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
    @(negedge clk);
    chk({14'h0000, irq, useDma}, 16'h0001);
    u_rxesq_host.wr(`RXESQ_OFS_CFG, 16'h0343);
    drain(1'b0);
    // Host clears DMA-always, then writes skip once and waits up to four cycles for skipFrame.
    u_rxesq_host.wr(`RXESQ_OFS_CFG, 16'h0003);
    u_rxesq_host.wr(`RXESQ_OFS_CFG, 16'h0043);
    i = 0;
    while (skipFrame !== 1'b1 && i < 4) begin
      @(negedge clk);
      i = i + 1;
    end
    chk({15'h0000, skipFrame}, 16'h0001);
    $display("test 4 done");
    // Stream enable together with the auto switch, one of the two DMA modes it needs.
    u_rxesq_host.wr(`RXESQ_OFS_CFG, 16'h0483);
    autoDmaCond = 1'b1;
    backToBack = 1'b1;
    repeat (3) @(negedge clk);
    chk({14'h0000, useDma, useStream}, 16'h0003);
    frame(11'd5, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk({14'h0000, frameAccept, frameDiscard}, 16'h0001);
    repeat (2) @(negedge clk);
    // Loader pulse: upper bits taken, skip forced clear, fixed code kept.
    eepromCfg = 16'hFFFF;
    eepromLoad = 1'b1;
    @(negedge clk);
    eepromLoad = 1'b0;
    u_rxesq_host.rd(1'b0, `RXESQ_OFS_CFG, rv);
    chk(rv, 16'hFF83);
    $display("test 5 done");
    end_sim;
  end
endmodule
